// file: sim/fault_interrupt_enable_regs_tb.sv
// Self-checking testbench for the fault interrupt enable registers
`timescale 1ns/1ps
module fault_interrupt_enable_regs_tb
    import fault_irq_pkg::*;
;
    logic              core_clk;
    logic              rstn;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wr_data;
    logic              wr_en;
    logic              rd_en;
    logic [DATA_W-1:0] rd_data;
    logic              irq;
    logic [9:0]        flt;
    logic [15:0]       got;
    logic [15:0]       exp_boost;
    logic [15:0]       exp_string;
    logic [15:0]       d;
    logic [31:0]       seed;
    int                failures;
    int                checks_done;

    fault_interrupt_enable_regs dut
    (
        .core_clk                          (core_clk),
        .rstn                              (rstn),
        .addr                              (addr),
        .wr_data                           (wr_data),
        .wr_en                             (wr_en),
        .rd_en                             (rd_en),
        .overtemp_fault                    (flt[9]),
        .current_resistor_short_fault      (flt[8]),
        .string_cfg_resistor_missing_fault (flt[7]),
        .mode_resistor_missing_fault       (flt[6]),
        .freq_resistor_missing_fault       (flt[5]),
        .boost_overcurrent_fault           (flt[4]),
        .boost_overvoltage_high_fault      (flt[3]),
        .bus_timeout_fault                 (flt[2]),
        .bad_string_cfg_fault              (flt[1]),
        .string_fault                      (flt[0]),
        .rd_data                           (rd_data),
        .irq                               (irq)
    );

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xorshift

    // Codes 0 and 2 and the reserved pairs keep the old value
    function automatic logic [15:0] apply_codes(input logic [15:0] cur, input logic [15:0] wd,
                                                input int lo, input int hi);
        logic [15:0] r;
        r = cur;
        for (int p = lo; p <= hi; p += 2)
        begin
            if (wd[p +: 2] == 2'h3)
                r[p +: 2] = 2'h2;
            else if (wd[p +: 2] == 2'h1)
                r[p +: 2] = 2'h0;
        end
        return r;
    endfunction : apply_codes

    // Indices 0..2 sit in the string-side pairs, 3..9 in the boost-side pairs from bit 2 up
    function automatic int fpos(input int i);
        return (i < 3) ? 2 * i : 2 * (i - 2);
    endfunction : fpos

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [15:0] wd);
        @(posedge core_clk);
        addr    <= a;
        wr_data <= wd;
        wr_en   <= 1'b1;
        @(posedge core_clk);
        wr_en   <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1;
        got = rd_data;
    endtask : rd

    // The interrupt output is registered, so it is looked at one edge after its cause
    task automatic irq_is(input logic e);
        @(posedge core_clk);
        #1;
        check({15'h0000, irq}, {15'h0000, e});
    endtask : irq_is

    task automatic tally_and_finish;
        $display("checks_done %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    initial
    begin
        repeat (20000) @(posedge core_clk);
        failures++;
        tally_and_finish();
    end

    initial
    begin
        logic [7:0] eo;
        logic [7:0] so;
        int         p;
        rstn = 1'b0; addr = 8'h00; wr_data = 16'h0000; wr_en = 1'b0; rd_en = 1'b0;
        flt = 10'h000; failures = 0; checks_done = 0; seed = 32'h6f2d;
        repeat (5) @(posedge core_clk);
        rstn <= 1'b1;
        rd(BOOST_EN_OFFSET);
        check(got, 16'ha028);
        rd(STRING_EN_OFFSET);
        check(got, 16'h00aa);
        wr(8'h55, 16'hffff);
        rd(8'h55);
        check(got, 16'h0000);
        rd(BOOST_EN_OFFSET);
        check(got, 16'ha028);
        irq_is(1'b0);
        exp_boost  = 16'ha028;
        exp_string = 16'h00aa;
        // Corner patterns first: all ones, all disable, all hold, all read-codes
        for (int k = 0; k < 44; k++)
        begin
            seed = xorshift(seed);
            d = (k == 0) ? 16'hffff : (k == 1) ? 16'h5555 : (k == 2) ? 16'h0000 :
                (k == 3) ? 16'haaaa : seed[15:0];
            wr(BOOST_EN_OFFSET, d);
            wr(STRING_EN_OFFSET, d ^ seed[31:16]);
            exp_boost  = apply_codes(exp_boost, d, 2, 14);
            exp_string = apply_codes(exp_string, d ^ seed[31:16], 0, 6);
            rd(BOOST_EN_OFFSET);
            check(got, exp_boost);
            rd(STRING_EN_OFFSET);
            check(got, exp_string);
        end
        wr(BOOST_EN_OFFSET, 16'hfffc);
        wr(STRING_EN_OFFSET, 16'h00ff);
        for (int i = 0; i < 10; i++)
        begin
            p  = fpos(i);
            eo = (i < 3) ? STRING_EN_OFFSET : BOOST_EN_OFFSET;
            so = (i < 3) ? STRING_STAT_OFFSET : BOOST_STAT_OFFSET;
            @(posedge core_clk);
            flt <= 10'h001 << i;
            @(posedge core_clk);
            flt <= 10'h000;
            irq_is(1'b1);
            wr(eo, 16'h0001 << p);
            irq_is(1'b0);
            wr(eo, 16'h0003 << p);
            irq_is(1'b1);
            wr(STRING_EN_OFFSET, 16'h0040);
            irq_is(1'b0);
            wr(STRING_EN_OFFSET, 16'h00c0);
            irq_is(1'b1);
            rd(so);
            check(got, 16'h0002 << p);
            wr(so, 16'h0002 << p);
            irq_is(1'b1);
            wr(so, 16'h0001 << p);
            irq_is(1'b1);
            wr(so, 16'h0003 << p);
            irq_is(1'b0);
            rd(so);
            check(got, 16'h0000);
        end
        // A fault present in the clearing cycle must survive the clear
        @(posedge core_clk);
        flt     <= 10'h200;
        addr    <= BOOST_STAT_OFFSET;
        wr_data <= 16'hc000;
        wr_en   <= 1'b1;
        @(posedge core_clk);
        flt     <= 10'h000;
        wr_en   <= 1'b0;
        irq_is(1'b1);
        rd(BOOST_STAT_OFFSET);
        check(got, 16'h8000);
        wr(BOOST_STAT_OFFSET, 16'hc000);
        irq_is(1'b0);
        // Write followed by a read with no gap between the strobes
        @(posedge core_clk);
        addr    <= BOOST_EN_OFFSET;
        wr_data <= 16'h4000;
        wr_en   <= 1'b1;
        @(posedge core_clk);
        wr_en   <= 1'b0;
        rd_en   <= 1'b1;
        @(posedge core_clk);
        rd_en   <= 1'b0;
        #1;
        check(rd_data, 16'h2aa8);
        tally_and_finish();
    end
endmodule : fault_interrupt_enable_regs_tb

// file: src/fault_flag.sv
// One latched fault flag with a paired status/clear write
`timescale 1ns/1ps
module fault_flag
(
    input  wire logic core_clk,
    input  wire logic rstn,
    input  wire logic set,
    input  wire logic clr,
    output logic      flag
);
    logic flag_reg;
    logic flag_next;

    // A fault present in the clearing cycle keeps the flag up
    assign flag_next = set | (flag_reg & ~clr); // see R17

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            flag_reg <= 1'b0;
        else
            flag_reg <= flag_next;
    end

    assign flag = flag_reg;

    set_wins_a: assert property (@(posedge core_clk) disable iff (!rstn) // see R17
        set |=> flag_reg)
        else $error("fault flag lost an event during clear");

    clear_a: assert property (@(posedge core_clk) disable iff (!rstn) // see R17
        (clr && !set) |=> !flag_reg)
        else $error("fault flag not cleared by paired write");

    hold_a: assert property (@(posedge core_clk) disable iff (!rstn) // see R17
        (flag_reg && !clr) |=> flag_reg)
        else $error("fault flag dropped without a clear");

endmodule : fault_flag

// file: src/fault_interrupt_enable_regs.sv
// Fault interrupt enable registers, latched fault flags and interrupt output
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps

// Contract
// R1: Boost-side enable register at offset 0x0A, 16 bits, resets to 0xA028.
// R2: Writing code 1 into an enable field disables that source.
// R3: Writing code 3 into an enable field enables that source.
// R4: A field reads 2 when enabled, 0 when disabled; low bit always zero.
// R5: Bits 15-14 gate over-temperature shutdown, enabled after reset.
// R6: Bits 13-12 gate current resistor short to ground, enabled after reset.
// R7: Bits 11-10 gate missing string-configuration resistor, disabled after reset.
// R8: Bits 9-8 gate missing mode-selection resistor, disabled after reset.
// R9: Bits 7-6 gate missing switching-frequency resistor, disabled after reset.
// R10: Bits 5-4 gate boost over-current, enabled after reset.
// R11: Bits 3-2 gate boost over-voltage high, enabled after reset.
// R12: Boost bits 1-0 and string bits 15-8 are reserved, read zero.
// R13: String-side register at 0x0C resets to 0xAA; master enable at bits 7-6.
// R14: String bits 5-4 gate serial bus timeout, enabled after reset.
// R15: String bits 3-2 gate invalid string configuration, enabled after reset.
// R16: String bits 1-0 gate combined string faults, enabled after reset.
// R17: A fault clears only when status and paired clear bit are written one.
// R18: Codes 0 and 2 leave an enable field unchanged.
// R19: Interrupt asserts only with master enable and an enabled latched fault.
module fault_interrupt_enable_regs
    import fault_irq_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rstn,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wr_data,
    input  wire logic              wr_en,
    input  wire logic              rd_en,
    input  wire logic              overtemp_fault,
    input  wire logic              current_resistor_short_fault,
    input  wire logic              string_cfg_resistor_missing_fault,
    input  wire logic              mode_resistor_missing_fault,
    input  wire logic              freq_resistor_missing_fault,
    input  wire logic              boost_overcurrent_fault,
    input  wire logic              boost_overvoltage_high_fault,
    input  wire logic              bus_timeout_fault,
    input  wire logic              bad_string_cfg_fault,
    input  wire logic              string_fault,
    output logic [DATA_W-1:0]      rd_data,
    output logic                   irq
);

    logic [N_SRC-1:0]  fault_in;
    logic [N_SRC-1:0]  en_reg;
    logic [N_SRC-1:0]  status;
    logic              master_en_reg;
    logic              master_en_next;
    logic [DATA_W-1:0] rd_data_reg;
    logic [DATA_W-1:0] rd_data_next;
    logic              irq_reg;
    logic              irq_next;

    wire               wr_boost_en;
    wire               wr_string_en;
    wire               wr_boost_stat;
    wire               wr_string_stat;
    wire  [DATA_W-1:0] boost_en_img;
    wire  [DATA_W-1:0] string_en_img;
    wire  [DATA_W-1:0] boost_stat_img;
    wire  [DATA_W-1:0] string_stat_img;
    wire  [DATA_W-1:0] read_mux;

    // Source order follows the field order, lowest field first
    assign fault_in = {overtemp_fault,
                       current_resistor_short_fault,
                       string_cfg_resistor_missing_fault,
                       mode_resistor_missing_fault,
                       freq_resistor_missing_fault,
                       boost_overcurrent_fault,
                       boost_overvoltage_high_fault,
                       bus_timeout_fault,
                       bad_string_cfg_fault,
                       string_fault};

    assign wr_boost_en    = wr_en && (addr == BOOST_EN_OFFSET);   // see R1
    assign wr_string_en   = wr_en && (addr == STRING_EN_OFFSET);  // see R13
    assign wr_boost_stat  = wr_en && (addr == BOOST_STAT_OFFSET);
    assign wr_string_stat = wr_en && (addr == STRING_STAT_OFFSET);

    // Reserved fields and unused clear positions read as zero
    assign boost_en_img[1:0]        = 2'h0;  // see R12
    assign string_en_img[15:8]      = 8'h00; // see R12
    assign boost_stat_img[1:0]      = 2'h0;
    assign string_stat_img[15:6]    = 10'h000;
    assign string_en_img[MASTER_POS+1:MASTER_POS] = field_read(master_en_reg); // see R4

    genvar j;
    generate
        for (j = 0; j < N_SRC; j++)
        begin : g_src
            localparam int  POS  = src_pos(j);
            localparam bit  BST  = src_is_boost(j);
            localparam logic RST = BST ? BOOST_EN_RESET[POS+1] : STRING_EN_RESET[POS+1];

            wire       wr_field;
            wire       clr;
            wire       en_next;
            wire [1:0] code;

            assign wr_field = BST ? wr_boost_en : wr_string_en;
            assign code     = wr_data[POS+1:POS];
            assign en_next  = wr_field ? field_next(en_reg[j], code) : en_reg[j]; // see R2, R3, R18
            // Both bits of the pair must be one; a lone status write is ignored
            assign clr      = (BST ? wr_boost_stat : wr_string_stat)
                              && wr_data[POS+1] && wr_data[POS]; // see R17

            // Reset picks each field's state from the register reset value
            always_ff @(posedge core_clk or negedge rstn)
            begin
                if (!rstn)
                    en_reg[j] <= RST; // see R5, R6, R7, R8, R9, R10, R11, R14, R15, R16
                else
                    en_reg[j] <= en_next;
            end

            fault_flag u_flag
            (
                .core_clk (core_clk),
                .rstn     (rstn),
                .set      (fault_in[j]),
                .clr      (clr),
                .flag     (status[j])
            );

            if (BST)
            begin : g_boost
                assign boost_en_img[POS+1:POS]   = field_read(en_reg[j]); // see R4
                assign boost_stat_img[POS+1:POS] = {status[j], 1'b0};
            end
            else
            begin : g_string
                assign string_en_img[POS+1:POS]   = field_read(en_reg[j]); // see R4
                assign string_stat_img[POS+1:POS] = {status[j], 1'b0};
            end
        end
    endgenerate

    assign master_en_next = wr_string_en ?
                            field_next(master_en_reg, wr_data[MASTER_POS+1:MASTER_POS]) :
                            master_en_reg; // see R13, R2, R3, R18

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            master_en_reg <= STRING_EN_RESET[MASTER_POS+1]; // see R13
        else
            master_en_reg <= master_en_next;
    end

    // Unmapped offsets read zero; data appear only in the cycle after the strobe
    assign read_mux = (addr == BOOST_EN_OFFSET)    ? boost_en_img    :
                      (addr == STRING_EN_OFFSET)   ? string_en_img   :
                      (addr == BOOST_STAT_OFFSET)  ? boost_stat_img  :
                      (addr == STRING_STAT_OFFSET) ? string_stat_img :
                      STAT_RESET;
    assign rd_data_next = rd_en ? read_mux : STAT_RESET;

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            rd_data_reg <= STAT_RESET;
        else
            rd_data_reg <= rd_data_next;
    end

    // Registered so the pin is glitch-free; costs one cycle of latency
    assign irq_next = master_en_reg && |(status & en_reg); // see R19

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            irq_reg <= 1'b0;
        else
            irq_reg <= irq_next;
    end

    assign rd_data = rd_data_reg;
    assign irq     = irq_reg;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    boost_reset_val_a: assert property ( // see R1
        $past(!rstn) |-> boost_en_img == BOOST_EN_RESET)
        else $error("boost enable register wrong after reset");

    string_reset_val_a: assert property ( // see R13
        $past(!rstn) |-> string_en_img == STRING_EN_RESET)
        else $error("string enable register wrong after reset");

    read_code_a: assert property ( // see R4
        rd_en && (addr == BOOST_EN_OFFSET || addr == STRING_EN_OFFSET)
        |=> (rd_data[0] == 1'b0) && (rd_data[2] == 1'b0) && (rd_data[4] == 1'b0)
            && (rd_data[6] == 1'b0) && (rd_data[8] == 1'b0))
        else $error("enable field read with low bit set");

    reserved_zero_a: assert property ( // see R12
        rd_en && addr == STRING_EN_OFFSET |=> rd_data[15:8] == 8'h00)
        else $error("reserved string bits not zero");

    boost_readback_a: assert property ( // see R1
        rd_en && addr == BOOST_EN_OFFSET |=> rd_data == $past(boost_en_img))
        else $error("boost enable read data mismatch");

    overtemp_off_a: assert property ( // see R2
        wr_boost_en && wr_data[OVERTEMP_POS+1:OVERTEMP_POS] == CODE_DISABLE
        ##1 rd_en && addr == BOOST_EN_OFFSET
        |=> rd_data[OVERTEMP_POS+1:OVERTEMP_POS] == READ_OFF)
        else $error("disable code did not turn source off");

    master_on_a: assert property ( // see R3
        wr_string_en && wr_data[MASTER_POS+1:MASTER_POS] == CODE_ENABLE
        |=> master_en_reg)
        else $error("enable code did not turn master on");

    code_hold_a: assert property ( // see R18
        wr_boost_en && !wr_data[OVERTEMP_POS] |=> $stable(en_reg[N_SRC-1]))
        else $error("neutral code changed an enable field");

    irq_cause_a: assert property ( // see R19
        irq |-> $past(master_en_reg) && ($past(status & en_reg) != '0))
        else $error("interrupt without enabled latched fault");

    irq_rise_a: assert property ( // see R19
        master_en_reg && (status & en_reg) != '0 |=> irq)
        else $error("interrupt missing for enabled fault");

    unmapped_zero_a: assert property ( // see R12
        rd_en && addr != BOOST_EN_OFFSET && addr != STRING_EN_OFFSET
        && addr != BOOST_STAT_OFFSET && addr != STRING_STAT_OFFSET
        |=> rd_data == STAT_RESET)
        else $error("unmapped read not zero");

    irq_seen_c: cover property (!irq ##1 irq);
    fault_cleared_c: cover property (irq ##1 wr_boost_stat ##[1:3] !irq);
    master_off_c: cover property (wr_string_en
        && wr_data[MASTER_POS+1:MASTER_POS] == CODE_DISABLE ##1 !master_en_reg);
    set_and_clear_c: cover property (wr_boost_stat && |fault_in);

endmodule : fault_interrupt_enable_regs

// file: src/fault_irq_pkg.sv
// Constants, field layout and field coding for the fault interrupt enable registers
package fault_irq_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // Register offsets
    localparam logic [7:0] BOOST_EN_OFFSET    = 8'h0a;
    localparam logic [7:0] STRING_EN_OFFSET   = 8'h0c;
    localparam logic [7:0] BOOST_STAT_OFFSET  = 8'h30;
    localparam logic [7:0] STRING_STAT_OFFSET = 8'h32;

    // Values after reset
    localparam logic [15:0] BOOST_EN_RESET  = 16'ha028;
    localparam logic [15:0] STRING_EN_RESET = 16'h00aa;
    localparam logic [15:0] STAT_RESET      = 16'h0000;

    // Write codes and read codes of a 2-bit enable field
    localparam logic [1:0] CODE_DISABLE = 2'h1;
    localparam logic [1:0] CODE_ENABLE  = 2'h3;
    localparam logic [1:0] READ_ON      = 2'h2;
    localparam logic [1:0] READ_OFF     = 2'h0;

    // Field low-bit positions
    localparam int OVERTEMP_POS        = 14;
    localparam int CURRENT_RES_POS     = 12;
    localparam int STRING_CFG_RES_POS  = 10;
    localparam int MODE_RES_POS        = 8;
    localparam int FREQ_RES_POS        = 6;
    localparam int BOOST_OC_POS        = 4;
    localparam int BOOST_OV_POS        = 2;
    localparam int MASTER_POS          = 6;
    localparam int BUS_TIMEOUT_POS     = 4;
    localparam int BAD_STRING_CFG_POS  = 2;
    localparam int STRING_FAULT_POS    = 0;

    // Sources: 0..2 live in the string-side register, 3..9 in the boost-side one
    localparam int N_STRING_SRC = 3;
    localparam int N_SRC        = 10;

    function automatic bit src_is_boost(input int j);
        return j >= N_STRING_SRC;
    endfunction : src_is_boost

    // Low bit of the source's field; the status register uses the same pair
    function automatic int src_pos(input int j);
        return src_is_boost(j) ? 2 * (j - N_STRING_SRC + 1) : 2 * j;
    endfunction : src_pos

    // Only the two defined codes act; the others leave the state alone
    function automatic logic field_next(input logic cur, input logic [1:0] code);
        if (code == CODE_ENABLE)
            return 1'b1;
        else if (code == CODE_DISABLE)
            return 1'b0;
        else
            return cur;
    endfunction : field_next

    function automatic logic [1:0] field_read(input logic en);
        return en ? READ_ON : READ_OFF;
    endfunction : field_read

endpackage : fault_irq_pkg
